// ==== verif/dbgbk_host.sv ====
// Debug host model issuing serial debug commands to the block.
// Assumes callers enter send() just after a rising clock edge.
`timescale 1ns/100ps
module dbgbk_host (
  input  wire logic        clk,
  output logic             write_breakpoint_cmd,
  output logic             read_breakpoint_cmd,
  output logic      [15:0] serial_wdata,
  output logic             frr_serial_wr,
  output logic             frr_rd,
  output logic      [7:0]  frr_wdata
);
  // ************************************************************
  // Command issue
  // ************************************************************
  initial begin
    {write_breakpoint_cmd, read_breakpoint_cmd, frr_serial_wr, frr_rd} = 4'h0;
    serial_wdata = 16'h0000;
    frr_wdata = 8'h00;
  end
  // Kind 0 bkpt write, 1 bkpt read, 2 force-reset write, 3 force-reset read
  task automatic send(input logic [1:0] kind, input logic [15:0] data);
    serial_wdata = data;
    frr_wdata = data[7:0];
    write_breakpoint_cmd = kind == 2'h0;
    read_breakpoint_cmd = kind == 2'h1;
    frr_serial_wr = kind == 2'h2;
    frr_rd = kind == 2'h3;
    @(posedge clk);
    #1;
    {write_breakpoint_cmd, read_breakpoint_cmd, frr_serial_wr, frr_rd} = 4'h0;
    // Released lines show the inverse, so stale data never looks valid
    serial_wdata = ~data;
    frr_wdata = ~data[7:0];
  endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the breakpoint and force-reset block.
// Assumes dbgbk_host stands in for the serial debug controller.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, frr_user_wr = 1'b0, cpu_fetch = 1'b0;
  logic breakpoint_enable_bit = 1'b0, force_or_tag_choice = 1'b0, insn_boundary = 1'b0;
  logic tag_exec = 1'b0, tag_flush = 1'b0, write_breakpoint_cmd, read_breakpoint_cmd;
  logic frr_serial_wr, frr_rd, fetch_tag, bkpt_request, force_reset, hit, fl;
  logic [15:0] serial_wdata, serial_rdata, bp, cpu_addr = 16'h0000;
  logic [7:0]  frr_wdata, frr_rdata, wd;
  int          fail_count = 0, check_count = 0, seed = 59;
  always #12.5 clk = ~clk;
  dbgbk_host host (.clk, .write_breakpoint_cmd, .read_breakpoint_cmd, .serial_wdata,
    .frr_serial_wr, .frr_rd, .frr_wdata);
  dbgbk_top uut (.clk, .rst, .breakpoint_enable_bit, .force_or_tag_choice,
    .write_breakpoint_cmd, .read_breakpoint_cmd, .serial_wdata, .serial_rdata,
    .frr_serial_wr, .frr_user_wr, .frr_rd, .frr_wdata, .frr_rdata, .cpu_addr, .cpu_fetch,
    .insn_boundary, .tag_exec, .tag_flush, .fetch_tag, .bkpt_request, .force_reset);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) cyc();
    rst = 1'b0;
    host.send(2'h1, 16'h0000);
    check(serial_rdata, 16'h0000);
    for (int i = 0; i < 64; i++) begin
      if (i % 8 == 0) begin
        bp = (i == 0) ? 16'hFFFF : 16'($random(seed));
        host.send(2'h0, bp);
        host.send(2'h1, 16'h0000);
        check(serial_rdata, bp);
      end
      wd = 8'($random(seed));
      host.send(2'h2, {8'h00, wd});
      check(force_reset, wd[0]);
      // CPU write lands alongside a read, with bit zero set
      frr_user_wr = 1'b1;
      host.send(2'h3, 16'h00FF);
      frr_user_wr = 1'b0;
      check(force_reset, 1'b0);
      check(frr_rdata, 8'h00);
      {breakpoint_enable_bit, force_or_tag_choice, fl} = 3'($random(seed));
      cpu_addr = (i % 3 == 0) ? bp ^ (16'h0001 << i[3:0]) : bp;
      hit = breakpoint_enable_bit && cpu_addr == bp;
      cpu_fetch = 1'b1;
      cyc();
      cpu_fetch = 1'b0;
      check(fetch_tag, hit & ~force_or_tag_choice);
      insn_boundary = 1'b1;
      #1;
      check(bkpt_request, hit & force_or_tag_choice);
      cyc();
      insn_boundary = 1'b0;
      {tag_flush, tag_exec} = {fl, ~fl};
      #1;
      check(bkpt_request, hit & ~force_or_tag_choice & ~fl);
      cyc();
      {tag_flush, tag_exec} = 2'h0;
      check(fetch_tag, 1'b0);
    end
    // Corner: a second hit while armed is not tagged again
    {breakpoint_enable_bit, force_or_tag_choice, cpu_addr, cpu_fetch} = {2'h2, bp, 1'b1};
    cyc();
    check(fetch_tag, 1'b1);
    cyc();
    cpu_fetch = 1'b0;
    check(fetch_tag, 1'b0);
    tag_exec = 1'b1;
    #1;
    check(bkpt_request, 1'b1);
    cyc();
    tag_exec = 1'b0;
    // Mid-run reset clears the breakpoint register
    rst = 1'b1;
    repeat (2) cyc();
    rst = 1'b0;
    check(force_reset, 1'b0);
    host.send(2'h1, 16'h0000);
    check(serial_rdata, 16'h0000);
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule

// ==== verilog/dbgbk_defs.svh ====
// Constants for the debug breakpoint and force-reset block.
// Assumes inclusion by bare name from the block's package or module.
`ifndef DBGBK_DEFS_SVH
`define DBGBK_DEFS_SVH

// ************************************************************
// Register layout and reset values
// ************************************************************
`define DBGBK_ADDR_W        16
`define DBGBK_BKPT_RESET    16'h0000
`define DBGBK_FRR_READ      8'h00
`define DBGBK_FRR_BIT       0

`endif

// ==== verilog/dbgbk_pkg.sv ====
// Types for the debug breakpoint and force-reset block.
// Assumes dbgbk_defs.svh is on the include path.
`include "dbgbk_defs.svh"

package dbgbk_pkg;
  typedef enum logic [1:0] {
    DBGBK_IDLE,
    DBGBK_TAGGED,
    DBGBK_FORCED
  } dbgbk_brk_type;
endpackage

// ==== verilog/dbgbk_top.sv ====
// Breakpoint match register and serial-only force-reset register.
// Assumes the serial debug controller decodes commands into one-cycle
// strobes on the bus clock, and the CPU core supplies bus and queue events.
// Limitation: only one tag can be outstanding; a hit while armed is dropped
// rather than queued, so a second fetch of the same address is not tagged.
// The force-reset output is a one-cycle pulse; system reset logic stretches it.
`timescale 1ns/100ps
`include "dbgbk_defs.svh"

module dbgbk_top
  import dbgbk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        breakpoint_enable_bit,
  input  wire logic        force_or_tag_choice,
  input  wire logic        write_breakpoint_cmd,
  input  wire logic        read_breakpoint_cmd,
  input  wire logic [15:0] serial_wdata,
  output logic      [15:0] serial_rdata,
  input  wire logic        frr_serial_wr,
  input  wire logic        frr_user_wr,
  input  wire logic        frr_rd,
  input  wire logic [7:0]  frr_wdata,
  output logic      [7:0]  frr_rdata,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_fetch,
  input  wire logic        insn_boundary,
  input  wire logic        tag_exec,
  input  wire logic        tag_flush,
  output logic             fetch_tag,
  output logic             bkpt_request,
  output logic             force_reset
);

  // ************************************************************
  // Breakpoint match register
  // ************************************************************
  logic [15:0]   breakpoint_match_address;
  dbgbk_brk_type state;
  dbgbk_brk_type next_state;
  logic          hit;

  // Written only from serial commands; no CPU path exists by design.
  always_ff @(posedge clk) begin
    if (rst) begin
      breakpoint_match_address <= `DBGBK_BKPT_RESET;
    end else if (write_breakpoint_cmd) begin
      breakpoint_match_address <= serial_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_rdata <= 16'h0000;
    end else if (read_breakpoint_cmd) begin
      serial_rdata <= breakpoint_match_address;
    end
  end

  // ************************************************************
  // Comparison and background request
  // ************************************************************
  assign hit = breakpoint_enable_bit && cpu_fetch
               && (cpu_addr == breakpoint_match_address);

  always_comb begin
    next_state = state;
    case (state)
      DBGBK_IDLE: begin
        if (hit && force_or_tag_choice) begin
          next_state = DBGBK_FORCED;
        end else if (hit) begin
          next_state = DBGBK_TAGGED;
        end
      end
      DBGBK_TAGGED: begin
        // Tag dies if the opcode is flushed before it executes
        if (tag_exec || tag_flush) begin
          next_state = DBGBK_IDLE;
        end
      end
      DBGBK_FORCED: begin
        if (insn_boundary) begin
          next_state = DBGBK_IDLE;
        end
      end
      default: next_state = DBGBK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DBGBK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_tag <= 1'b0;
    end else begin
      // Only a hit from idle tags; a hit while armed would double-tag
      fetch_tag <= hit && !force_or_tag_choice && (state == DBGBK_IDLE);
    end
  end

  assign bkpt_request = ((state == DBGBK_FORCED) && insn_boundary)
                        || ((state == DBGBK_TAGGED) && tag_exec);

  // ************************************************************
  // Force-reset register
  // ************************************************************
  // Only a serial write counts; user writes never reach the flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      force_reset <= 1'b0;
    end else begin
      force_reset <= frr_serial_wr && frr_wdata[`DBGBK_FRR_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frr_rdata <= `DBGBK_FRR_READ;
    end else if (frr_rd) begin
      frr_rdata <= `DBGBK_FRR_READ;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  bkpt_write_a: assert property (@(posedge clk) disable iff (rst)
    write_breakpoint_cmd |=> breakpoint_match_address == $past(serial_wdata))
    else $error("breakpoint write lost");
  bkpt_read_a: assert property (@(posedge clk) disable iff (rst)
    read_breakpoint_cmd |=> serial_rdata == $past(breakpoint_match_address))
    else $error("breakpoint read wrong");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !breakpoint_enable_bit |=> !fetch_tag)
    else $error("tag while disabled");
  full_match_a: assert property (@(posedge clk) disable iff (rst)
    hit |-> cpu_addr == breakpoint_match_address && breakpoint_enable_bit)
    else $error("partial match");
  force_mode_a: assert property (@(posedge clk) disable iff (rst)
    (state == DBGBK_IDLE && hit && force_or_tag_choice) ##1 insn_boundary
    |-> bkpt_request)
    else $error("force request missing");
  tag_mode_a: assert property (@(posedge clk) disable iff (rst)
    (state == DBGBK_IDLE && hit && !force_or_tag_choice) |=> fetch_tag
    && state == DBGBK_TAGGED)
    else $error("tag missing");
  user_ignored_a: assert property (@(posedge clk) disable iff (rst)
    !frr_serial_wr |=> !force_reset)
    else $error("reset from user write");
  serial_reset_a: assert property (@(posedge clk) disable iff (rst)
    frr_serial_wr && frr_wdata[0] |=> force_reset)
    else $error("serial reset lost");
  read_zero_a: assert property (@(posedge clk) disable iff (rst)
    frr_rd ##1 1'b1 |-> frr_rdata == 8'h00)
    else $error("reset register read nonzero");

  // ************************************************************
  // Further checks on arming and user writes
  // ************************************************************
  // A CPU write alone must never reach the reset pulse
  user_write_a: assert property (@(posedge clk) disable iff (rst)
    frr_user_wr && !frr_serial_wr |=> !force_reset)
    else $error("user write forced reset");
  armed_ignore_a: assert property (@(posedge clk) disable iff (rst)
    state != DBGBK_IDLE && hit |=> !fetch_tag)
    else $error("hit tagged while armed");
  tag_exec_a: assert property (@(posedge clk) disable iff (rst)
    state == DBGBK_TAGGED && tag_exec |-> bkpt_request)
    else $error("tagged opcode ran");
  force_wait_a: assert property (@(posedge clk) disable iff (rst)
    state == DBGBK_FORCED && !insn_boundary |-> !bkpt_request)
    else $error("force request early");
  idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
    state == DBGBK_IDLE |-> !bkpt_request)
    else $error("request while idle");

endmodule
